/* design/smrse_top.v */
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "smrse_consts.vh"
// Service-mode rate, save and exit command interpreter
module smrse_top #(
	parameter [31:0] HOLD_CYCLES = `SMRSE_HOLD_CYC,
	parameter [2:0]  RST_RATE    = `SMRSE_R125
)(
	input  wire        I_CLK,
	input  wire        I_RST_N,
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [7:0]  I_PADDR,
	input  wire [31:0] I_PWDATA,
	output reg  [31:0] O_PRDATA,
	output wire        O_PREADY,
	output wire        O_PSLVERR,
	input  wire [7:0]  I_RX_DATA,
	input  wire        I_RX_VALID,
	output wire        O_RX_READY,
	output wire        O_RSP_VALID,
	output wire [3:0]  O_RSP_CODE,
	output reg  [15:0] O_RSP_ARG,
	input  wire        I_RSP_READY,
	output wire        O_NVM_REQ,
	output wire [2:0]  O_NVM_DATA,
	input  wire        I_NVM_DONE,
	input  wire        I_NVM_FAIL,
	output wire [2:0]  O_RATE_SEL,
	output wire        O_EXT_TRIG,
	output wire [2:0]  O_MODE
);
	localparam [4:0] S_LINE = 5'h01;
	localparam [4:0] S_SCNF = 5'h02;
	localparam [4:0] S_XCNF = 5'h04;
	localparam [4:0] S_NVM  = 5'h08;
	localparam [4:0] S_HOLD = 5'h10;

	reg  [4:0]  st_q;
	reg  [2:0]  mode_q;
	reg  [2:0]  rate_q;
	reg         xinit_q;
	reg         hstart_q;
	reg  [11:0] seq_q;
	reg         hcmd_q;
	reg  [7:0]  cmd_q;
	reg         after_q;
	reg         first_q;
	reg         glued_q;
	reg         comma_q;
	reg         psep_q;
	reg  [1:0]  np_q;
	reg  [1:0]  plen_q;
	reg  [7:0]  pch_q;
	reg         nd_q;
	reg         ovf_q;
	reg  [10:0] val_q;
	wire [2:0]  img_rate;
	wire [15:0] img_cnt;
	wire        t_done;
	wire        t_busy;
	wire        img_we;
	wire        t_start;
	wire        rx_take;
	wire        is_sep;
	wire        is_dig;
	wire [3:0]  rx_dig;
	wire [13:0] dec_nx;
	wire [15:0] cnt_nx;
	wire        dirty;
	wire        apb_wr;
	wire        apb_hit;
	wire [3:0]  rchk;

	// Map a parsed value to {valid, rate code}
	function [3:0] rate_of;
		input [10:0] v;
		begin
			case (v)
				11'h000: rate_of = {1'b1, `SMRSE_REXT};
				11'h07D: rate_of = {1'b1, `SMRSE_R125};
				11'h0FA: rate_of = {1'b1, `SMRSE_R250};
				11'h1F4: rate_of = {1'b1, `SMRSE_R500};
				11'h3E8: rate_of = {1'b1, `SMRSE_R1000};
				default: rate_of = 4'h0;
			endcase
		end
	endfunction

	// Error code followed by a prompt
	function [11:0] err_seq;
		input [3:0] c;
		begin
			err_seq = {4'h0, `SMRSE_C_PROMPT, c};
		end
	endfunction

	// ==========================================
	// Submodules
	smrse_cfg_img #(
		.RW       (3),
		.CW       (16),
		.RST_RATE (RST_RATE)
	) u_img (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_we    (img_we),
		.i_rate  (rate_q),
		.o_rate  (img_rate),
		.o_cnt   (img_cnt)
	);

	smrse_hold_tmr #(
		.N (HOLD_CYCLES)
	) u_hold (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_start (t_start),
		.o_done  (t_done),
		.o_busy  (t_busy)
	);

	// ==========================================
	// Character decode and handshakes
	assign O_RX_READY  = (mode_q == `SMRSE_M_SVC) && (seq_q == 12'h000)
		&& (st_q[0] || st_q[1] || st_q[2]);
	assign rx_take     = I_RX_VALID && O_RX_READY;
	assign is_sep      = (I_RX_DATA == `SMRSE_CH_SP) || (I_RX_DATA == `SMRSE_CH_COMMA);
	assign is_dig      = (I_RX_DATA >= `SMRSE_CH_0) && (I_RX_DATA <= `SMRSE_CH_9);
	assign rx_dig      = I_RX_DATA[3:0];
	assign dec_nx      = {val_q, 3'h0} + {2'h0, val_q, 1'h0} + {10'h000, rx_dig};
	assign rchk        = rate_of(val_q);
	assign dirty       = (rate_q != img_rate);
	assign cnt_nx      = img_cnt + 16'h0001;
	assign O_RSP_VALID = (seq_q[3:0] != `SMRSE_C_NONE);
	assign O_RSP_CODE  = seq_q[3:0];
	// RULE10 always write
	assign O_NVM_REQ   = st_q[3];
	assign O_NVM_DATA  = rate_q;
	// RULE8 image commit
	assign img_we      = st_q[3] && I_NVM_DONE;
	// RULE17 hold after response
	assign t_start     = st_q[4] && !hstart_q && (seq_q == 12'h000);
	// RULE1 one shared rate
	assign O_RATE_SEL  = rate_q;
	assign O_EXT_TRIG  = (rate_q == `SMRSE_REXT);
	assign O_MODE      = mode_q;

	// ==========================================
	// APB slave, zero wait states
	assign O_PREADY  = 1'b1;
	assign apb_hit   = (I_PADDR == `SMRSE_OFS_CTRL) || (I_PADDR == `SMRSE_OFS_STAT)
		|| (I_PADDR == `SMRSE_OFS_SCNT);
	assign O_PSLVERR = I_PSEL && I_PENABLE && !apb_hit;
	assign apb_wr    = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `SMRSE_OFS_CTRL);

	// Read data captured in the setup cycle
	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_PRDATA <= 32'h0000_0000;
		else if (I_PSEL && !I_PENABLE && !I_PWRITE)
		begin
			case (I_PADDR)
				`SMRSE_OFS_STAT: O_PRDATA <= {18'h00000, st_q, xinit_q, dirty, 
					t_busy, mode_q, rate_q};
				`SMRSE_OFS_SCNT: O_PRDATA <= {16'h0000, img_cnt};
				default:         O_PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// Command interpreter
	always @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			st_q     <= S_LINE;
			// RULE5 reset reloads image
			mode_q   <= `SMRSE_M_INIT;
			rate_q   <= RST_RATE;
			xinit_q  <= 1'b0;
			hstart_q <= 1'b0;
			seq_q    <= 12'h000;
			O_RSP_ARG <= 16'h0000;
			hcmd_q   <= 1'b0;
			cmd_q    <= 8'h00;
			after_q  <= 1'b0;
			first_q  <= 1'b0;
			glued_q  <= 1'b0;
			comma_q  <= 1'b0;
			psep_q   <= 1'b0;
			np_q     <= 2'h0;
			plen_q   <= 2'h0;
			pch_q    <= 8'h00;
			nd_q     <= 1'b0;
			ovf_q    <= 1'b0;
			val_q    <= 11'h000;
		end
		else
		begin
			// Response queue shifts out one code per accept
			if (O_RSP_VALID && I_RSP_READY)
				seq_q <= {4'h0, seq_q[11:4]};
			// Line parse state clears at CR and outside service
			if ((mode_q != `SMRSE_M_SVC) || (rx_take && I_RX_DATA == `SMRSE_CH_CR)
				|| !st_q[0])
			begin
				hcmd_q  <= 1'b0;
				after_q <= 1'b0;
				first_q <= 1'b0;
				glued_q <= 1'b0;
				comma_q <= 1'b0;
				psep_q  <= 1'b0;
				np_q    <= 2'h0;
				plen_q  <= 2'h0;
				nd_q    <= 1'b0;
				ovf_q   <= 1'b0;
				val_q   <= 11'h000;
			end
			else if (rx_take && !hcmd_q)
			begin
				if (I_RX_DATA != `SMRSE_CH_SP)
				begin
					hcmd_q  <= 1'b1;
					cmd_q   <= I_RX_DATA;
					first_q <= 1'b1;
				end
			end
			else if (rx_take)
			begin
				after_q <= 1'b1;
				first_q <= 1'b0;
				// RULE7 comma after letter
				if (first_q && I_RX_DATA == `SMRSE_CH_COMMA)
					comma_q <= 1'b1;
				if (first_q && !is_sep)
					glued_q <= 1'b1;
				psep_q <= is_sep;
				if (!is_sep)
				begin
					if (psep_q && np_q != 2'h3)
						np_q <= np_q + 2'h1;
					if (plen_q != 2'h3)
						plen_q <= plen_q + 2'h1;
					if (plen_q == 2'h0)
						pch_q <= I_RX_DATA;
					if (is_dig)
					begin
						val_q <= dec_nx[10:0];
						if (|dec_nx[13:11])
							ovf_q <= 1'b1;
					end
					else
						nd_q <= 1'b1;
				end
			end
			// Software mode requests
			if (apb_wr && I_PWDATA[`SMRSE_CTRL_INIT])
				mode_q <= `SMRSE_M_INIT;
			else if (apb_wr && I_PWDATA[`SMRSE_CTRL_SVC] && mode_q == `SMRSE_M_NORM)
			begin
				mode_q <= `SMRSE_M_SVC;
				st_q   <= S_LINE;
				seq_q  <= {8'h00, `SMRSE_C_PROMPT};
			end
			// RULE21 init reloads image
			else if (mode_q == `SMRSE_M_INIT)
			begin
				rate_q <= img_rate;
				mode_q <= `SMRSE_M_NORM;
				st_q   <= S_LINE;
			end
			else if (mode_q == `SMRSE_M_SVC)
			begin
				case (st_q)
					S_LINE:
					begin
						if (rx_take && I_RX_DATA == `SMRSE_CH_CR && hcmd_q)
						begin
							// RULE6 unknown command
							if (glued_q)
								seq_q <= err_seq(`SMRSE_C_E001);
							else if (cmd_q == `SMRSE_CH_M)
							begin
								// RULE7 parameter count
								if (comma_q || np_q != 2'h1)
									seq_q <= err_seq(`SMRSE_C_E002);
								// RULE2 rate accepted
								else if (!nd_q && !ovf_q && rchk[3])
								begin
									// RULE4 no undersampling warning
									rate_q    <= rchk[2:0];
									O_RSP_ARG <= {5'h00, val_q};
									// RULE3 external trigger reply
									if (rchk[2:0] == `SMRSE_REXT)
										seq_q <= {4'h0, `SMRSE_C_PROMPT, `SMRSE_C_EXT};
									else
										seq_q <= {4'h0, `SMRSE_C_PROMPT, `SMRSE_C_RATE};
								end
								else
									seq_q <= err_seq(`SMRSE_C_E003);
							end
							else if (cmd_q == `SMRSE_CH_S)
							begin
								// RULE14 trailing characters
								if (after_q)
									seq_q <= err_seq(`SMRSE_C_E002);
								else
								begin
									// RULE11 ask confirmation
									seq_q <= {8'h00, `SMRSE_C_SASK};
									st_q  <= S_SCNF;
								end
							end
							else if (cmd_q == `SMRSE_CH_X)
							begin
								if (comma_q || np_q != 2'h1)
									seq_q <= err_seq(`SMRSE_C_E002);
								else if (plen_q != 2'h1)
									seq_q <= err_seq(`SMRSE_C_E003);
								else if (pch_q == `SMRSE_CH_N || pch_q == `SMRSE_CH_I)
								begin
									// RULE18 init target
									xinit_q  <= (pch_q == `SMRSE_CH_I);
									hstart_q <= 1'b0;
									// RULE17 confirm when dirty
									if (dirty)
									begin
										seq_q <= {8'h00, `SMRSE_C_XASK};
										st_q  <= S_XCNF;
									end
									else
									begin
										// RULE22 return announcement
										seq_q <= (pch_q == `SMRSE_CH_I) ?
											{8'h00, `SMRSE_C_RINIT} : {8'h00, `SMRSE_C_RNORM};
										st_q  <= S_HOLD;
									end
								end
								// RULE19 immediate normal exit
								else if (pch_q == `SMRSE_CH_UN)
								begin
									seq_q  <= {8'h00, `SMRSE_C_RNORM};
									mode_q <= `SMRSE_M_NORM;
								end
								// RULE20 immediate init exit
								else if (pch_q == `SMRSE_CH_UI)
								begin
									seq_q  <= {8'h00, `SMRSE_C_RINIT};
									mode_q <= `SMRSE_M_INIT;
								end
								else
									seq_q <= err_seq(`SMRSE_C_E003);
							end
							else
								seq_q <= err_seq(`SMRSE_C_E001);
						end
					end
					S_SCNF:
					begin
						if (rx_take)
						begin
							// RULE11 upper-case Y proceeds
							if (I_RX_DATA == `SMRSE_CH_UY)
								st_q <= S_NVM;
							else
							begin
								st_q <= S_LINE;
								// RULE12 N aborts
								if (I_RX_DATA == `SMRSE_CH_UN)
									seq_q <= {4'h0, `SMRSE_C_PROMPT, `SMRSE_C_ABORT};
								// RULE13 other aborts, E003
								else
									seq_q <= {`SMRSE_C_PROMPT, `SMRSE_C_E003, `SMRSE_C_ABORT};
							end
						end
					end
					S_NVM:
					begin
						if (I_NVM_DONE)
						begin
							st_q      <= S_LINE;
							O_RSP_ARG <= cnt_nx;
							// RULE9 limit warning
							if (cnt_nx > `SMRSE_SAVE_LIM)
								seq_q <= {`SMRSE_C_PROMPT, `SMRSE_C_E004, `SMRSE_C_SAVED};
							// RULE16 stored with count
							else
								seq_q <= {4'h0, `SMRSE_C_PROMPT, `SMRSE_C_SAVED};
						end
						// RULE15 write failure
						else if (I_NVM_FAIL)
						begin
							st_q  <= S_LINE;
							seq_q <= err_seq(`SMRSE_C_E005);
						end
					end
					S_XCNF:
					begin
						if (rx_take)
						begin
							if (I_RX_DATA == `SMRSE_CH_UY)
							begin
								seq_q <= xinit_q ? {8'h00, `SMRSE_C_RINIT} :
									{8'h00, `SMRSE_C_RNORM};
								st_q  <= S_HOLD;
							end
							else
							begin
								st_q <= S_LINE;
								// RULE24 prompt when declined
								if (I_RX_DATA == `SMRSE_CH_UN)
									seq_q <= {8'h00, `SMRSE_C_PROMPT};
								else
									seq_q <= err_seq(`SMRSE_C_E003);
							end
						end
					end
					S_HOLD:
					begin
						if (t_start)
							hstart_q <= 1'b1;
						// RULE18 leave after hold
						if (t_done)
						begin
							mode_q <= xinit_q ? `SMRSE_M_INIT : `SMRSE_M_NORM;
							st_q   <= S_LINE;
						end
					end
					default:
						st_q <= S_LINE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* include/smrse_consts.vh */
`ifndef SMRSE_CONSTS_VH
`define SMRSE_CONSTS_VH
// Functional notes
// RULE1: One sample rate shared by all channels
// RULE2: Accept 125, 250, 500, 1000 sps rates
// RULE3: Rate zero selects external trigger, reported
// RULE4: No warning for any filter/rate mix
// RULE5: Unsaved settings lost at init or reset
// RULE6: E001 unknown, E002 count, E003 value
// RULE7: Comma after command letter gives E002
// RULE8: Save writes configuration to non-volatile store
// RULE9: Count saves; beyond 1000 warn E004
// RULE10: Always attempt write when save confirmed
// RULE11: Save asks confirmation; host answers Y
// RULE12: Answer N aborts save, reports abort
// RULE13: Other answer aborts save with E003
// RULE14: Characters after save letter give E002
// RULE15: Failed non-volatile write reports E005
// RULE16: Successful save reports stored and count
// RULE17: Exit n confirms if dirty, 3 s hold
// RULE18: Exit i same, then enters init mode
// RULE19: Exit N leaves immediately, no confirmation
// RULE20: Exit I enters init immediately
// RULE21: Init mode reloads parameters from store
// RULE22: Announce return to normal mode
// RULE23: Host sends letter, spaced params, CR
// RULE24: Prompt after each response or error; code sends no prompt after SASK, XASK, RNORM or RINIT

// ==========================================
// Register map
`define SMRSE_OFS_CTRL   8'h00
`define SMRSE_OFS_STAT   8'h04
`define SMRSE_OFS_SCNT   8'h08
`define SMRSE_CTRL_SVC   0
`define SMRSE_CTRL_INIT  1

// ==========================================
// Rate codes
`define SMRSE_R125       3'h0
`define SMRSE_R250       3'h1
`define SMRSE_R500       3'h2
`define SMRSE_R1000      3'h3
`define SMRSE_REXT       3'h4
`define SMRSE_SAVE_LIM   16'h03E8

// ==========================================
// Mode codes, one-hot
`define SMRSE_M_NORM     3'h1
`define SMRSE_M_SVC      3'h2
`define SMRSE_M_INIT     3'h4

// ==========================================
// Response codes
`define SMRSE_C_NONE     4'h0
`define SMRSE_C_PROMPT   4'h1
`define SMRSE_C_RATE     4'h2
`define SMRSE_C_EXT      4'h3
`define SMRSE_C_SASK     4'h4
`define SMRSE_C_SAVED    4'h5
`define SMRSE_C_ABORT    4'h6
`define SMRSE_C_XASK     4'h7
`define SMRSE_C_RNORM    4'h8
`define SMRSE_C_RINIT    4'h9
`define SMRSE_C_E001     4'hA
`define SMRSE_C_E002     4'hB
`define SMRSE_C_E003     4'hC
`define SMRSE_C_E004     4'hD
`define SMRSE_C_E005     4'hE

// ==========================================
// Characters
`define SMRSE_CH_CR      8'h0D
`define SMRSE_CH_SP      8'h20
`define SMRSE_CH_COMMA   8'h2C
`define SMRSE_CH_0       8'h30
`define SMRSE_CH_9       8'h39
`define SMRSE_CH_M       8'h6D
`define SMRSE_CH_S       8'h73
`define SMRSE_CH_X       8'h78
`define SMRSE_CH_N       8'h6E
`define SMRSE_CH_I       8'h69
`define SMRSE_CH_UN      8'h4E
`define SMRSE_CH_UI      8'h49
`define SMRSE_CH_UY      8'h59

// ==========================================
// Timing
`define SMRSE_CLK_HZ     250000000
`define SMRSE_HOLD_S     3
`define SMRSE_HOLD_CYC   (`SMRSE_HOLD_S * `SMRSE_CLK_HZ)
`endif

/* design/smrse_cfg_img.v */
`timescale 1ns/10ps
`default_nettype none
// Stored configuration image and save counter
module smrse_cfg_img #(
	parameter       RW       = 3,
	parameter       CW       = 16,
	parameter [2:0] RST_RATE = 3'h0
)(
	input  wire          i_clk,
	input  wire          i_rst_n,
	input  wire          i_we,
	input  wire [RW-1:0] i_rate,
	output reg  [RW-1:0] o_rate,
	output reg  [CW-1:0] o_cnt
);
	// ==========================================
	// Image write, counter saturates at all ones
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rate <= RST_RATE;
			o_cnt  <= {CW{1'b0}};
		end
		else if (i_we)
		begin
			o_rate <= i_rate;
			if (~&o_cnt)
				o_cnt <= o_cnt + {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

/* design/smrse_hold_tmr.v */
`timescale 1ns/10ps
`default_nettype none
// Down counter giving one done pulse N cycles after start
module smrse_hold_tmr #(
	parameter [31:0] N = 32'h0000_0001
)(
	input  wire i_clk,
	input  wire i_rst_n,
	input  wire i_start,
	output reg  o_done,
	output reg  o_busy
);
	reg [31:0] cnt_q;

	// ==========================================
	// Countdown
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_q  <= 32'h0000_0000;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_start)
			begin
				cnt_q  <= N - 32'h0000_0001;
				o_busy <= 1'b1;
			end
			else if (o_busy)
			begin
				if (cnt_q == 32'h0000_0000)
				begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 32'h0000_0001;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/smrse_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "smrse_consts.vh"
// ==========================================
// Port-level properties of the interpreter
module smrse_checker #(
	parameter [31:0] HOLD_CYCLES = 32'h0000_0014
)(
	input wire logic        I_CLK,
	input wire logic        I_RST_N,
	input wire logic        O_RX_READY,
	input wire logic        O_RSP_VALID,
	input wire logic [3:0]  O_RSP_CODE,
	input wire logic [15:0] O_RSP_ARG,
	input wire logic        I_RSP_READY,
	input wire logic        O_NVM_REQ,
	input wire logic [2:0]  O_NVM_DATA,
	input wire logic        I_NVM_DONE,
	input wire logic        I_NVM_FAIL,
	input wire logic [2:0]  O_RATE_SEL,
	input wire logic        O_EXT_TRIG,
	input wire logic [2:0]  O_MODE
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// ==========================================
	// Rate, flash, response and mode relations
	a_rate_legal: assert property (O_RATE_SEL <= `SMRSE_REXT)
		else $error("rate code out of range");
	a_ext_flag: assert property (O_EXT_TRIG == (O_RATE_SEL == `SMRSE_REXT))
		else $error("external trigger flag wrong");
	a_rate_reply: assert property ($changed(O_RATE_SEL) && O_MODE == `SMRSE_M_SVC |->
		##[0:2] O_RSP_VALID && O_RSP_CODE inside {`SMRSE_C_RATE, `SMRSE_C_EXT})
		else $error("rate changed without reply");
	a_nvm_data: assert property (O_NVM_REQ |-> O_NVM_DATA == O_RATE_SEL)
		else $error("flash data differs from live rate");
	a_nvm_wait: assert property (O_NVM_REQ && !I_NVM_DONE && !I_NVM_FAIL |=> O_NVM_REQ)
		else $error("flash request dropped early");
	a_rsp_held: assert property (O_RSP_VALID && !I_RSP_READY |=>
		O_RSP_VALID && $stable(O_RSP_CODE) && $stable(O_RSP_ARG))
		else $error("response changed while stalled");
	a_rx_gate: assert property (O_RSP_VALID || O_NVM_REQ |-> !O_RX_READY)
		else $error("input taken while busy");
	a_rx_svc: assert property (O_RX_READY |-> O_MODE == `SMRSE_M_SVC)
		else $error("input taken outside service");
	a_mode_hot: assert property ($onehot(O_MODE))
		else $error("mode not one-hot");
	a_init_out: assert property (O_MODE == `SMRSE_M_INIT |-> ##[1:2] O_MODE == `SMRSE_M_NORM)
		else $error("init mode not left");
	// Main scenarios reached
	c_saved: cover property (O_RSP_VALID && O_RSP_CODE == `SMRSE_C_SAVED);
	c_warn: cover property (O_RSP_VALID && O_RSP_CODE == `SMRSE_C_E004);
	c_init: cover property (O_MODE == `SMRSE_M_INIT);
endmodule
`default_nettype wire

/* bench/smrse_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Flash controller and response sink model
module smrse_far_model (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_nvm_req,
	input  wire logic i_fail,
	input  wire logic i_stall,
	output logic      o_nvm_done,
	output logic      o_nvm_fail,
	output logic      o_rsp_ready
);
	logic [1:0] wait_q;
	// Sink refuses codes while stalled
	assign o_rsp_ready = !i_stall;
	// failure injected on demand
	// Write ends four cycles into a request with a one-cycle answer
	always @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			wait_q <= 2'h0;
			o_nvm_done <= 1'h0;
			o_nvm_fail <= 1'h0;
		end
		else
		begin
			o_nvm_done <= 1'h0;
			o_nvm_fail <= 1'h0;
			if (i_nvm_req && !o_nvm_done && !o_nvm_fail)
			begin
				wait_q <= wait_q + 2'h1;
				if (wait_q == 2'h3)
				begin
					o_nvm_done <= !i_fail;
					o_nvm_fail <= i_fail;
				end
			end
		end
endmodule
`default_nettype wire

/* bench/smrse_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "smrse_consts.vh"
// ==========================================
// Self-checking bench with queue scoreboard
module service_mode_rate_save_exit_tb_top;
	localparam int H = 20;
	logic        clk, rst_n, psel, penable, pwrite, rx_valid, stall, fail, rnd;
	logic        pready, pslverr, se, rx_ready, rsp_valid, rsp_ready;
	logic        nvm_req, nvm_done, nvm_fail, ext_trig;
	logic [7:0]  paddr, rx_data;
	logic [31:0] pwdata, prdata, r;
	logic [31:0] xs = 32'hFDF765FD;
	logic [3:0]  rsp_code;
	logic [15:0] rsp_arg;
	logic [2:0]  nvm_data, rate_sel, mode;
	logic [20:0] q[$];
	logic [20:0] me;
	integer      errors, total_checks, i, n;
	string       rs[5] = '{"125", "250", "500", "1000", "0"};
	logic [15:0] av[4] = '{16'h007D, 16'h00FA, 16'h01F4, 16'h03E8};
	string       el[8] = '{"q", "mx", "m,500", "m 300", "m", "m 5 1", "s 1", "x q"};
	logic [3:0]  ec[8] = '{`SMRSE_C_E001, `SMRSE_C_E001, `SMRSE_C_E002, `SMRSE_C_E003,
		`SMRSE_C_E002, `SMRSE_C_E002, `SMRSE_C_E002, `SMRSE_C_E003};

	smrse_top #(.HOLD_CYCLES(32'h0000_0014)) u_smrse_top (
		.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_DATA(rx_data),
		.I_RX_VALID(rx_valid), .O_RX_READY(rx_ready), .O_RSP_VALID(rsp_valid),
		.O_RSP_CODE(rsp_code), .O_RSP_ARG(rsp_arg), .I_RSP_READY(rsp_ready),
		.O_NVM_REQ(nvm_req), .O_NVM_DATA(nvm_data), .I_NVM_DONE(nvm_done),
		.I_NVM_FAIL(nvm_fail), .O_RATE_SEL(rate_sel), .O_EXT_TRIG(ext_trig), .O_MODE(mode));
	smrse_far_model u_smrse_far_model (.i_clk(clk), .i_rst_n(rst_n), .i_nvm_req(nvm_req),
		.i_fail(fail), .i_stall(stall), .o_nvm_done(nvm_done), .o_nvm_fail(nvm_fail),
		.o_rsp_ready(rsp_ready));

	// Clock
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	function automatic [31:0] xsf(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xsf = t ^ (t << 5);
		end
	endfunction
	// Random stalls of the response sink
	always @(posedge clk)
	begin
		xs <= xsf(xs);
		stall <= rnd & xs[0];
	end
	// Scoreboard: oldest expected code against each accepted one
	always @(negedge clk)
		if (rsp_valid === 1'h1 && rsp_ready === 1'h1)
		begin
			me = q.size() ? q.pop_front() : 21'h000000;
			chk("rsp code", me[19:16], rsp_code);
			if (me[20])
				chk("rsp arg", me[15:0], rsp_arg);
		end

	task chk(input string s, input [31:0] e, input [31:0] v);
		begin
			total_checks++;
			if (e !== v)
			begin
				errors++;
				$display("BAD %s exp %0h got %0h", s, e, v);
			end
		end
	endtask
	task e(input [3:0] c);
		q.push_back({1'h0, c, 16'h0000});
	endtask
	task ea(input [3:0] c, input [15:0] a);
		q.push_back({1'h1, c, a});
	endtask
	task pr;
		e(`SMRSE_C_PROMPT);
	endtask
	task tmo;
		begin
			errors++;
			$display("BAD wait exp 1 got 0");
			stop_test;
		end
	endtask
	// Character handshake: hold until taken
	task send(input [7:0] c);
		integer k;
		begin
			@(posedge clk);
			rx_data <= c;
			rx_valid <= 1'h1;
			k = 0;
			@(negedge clk);
			while (rx_ready !== 1'h1 && k < 3000)
			begin
				@(negedge clk);
				k++;
			end
			if (k >= 3000)
				tmo;
			@(posedge clk);
			rx_valid <= 1'h0;
		end
	endtask
	task line(input string s);
		begin
			for (int j = 0; j < s.len(); j++)
				send(s[j]);
			send(`SMRSE_CH_CR);
		end
	endtask
	task drain;
		begin
			n = 0;
			while ((q.size() != 0 || rsp_valid !== 1'h0) && n < 3000)
			begin
				@(negedge clk);
				n++;
			end
			if (n >= 3000)
				tmo;
		end
	endtask
	task wm(input [2:0] m);
		begin
			n = 0;
			while (mode !== m && n < 3000)
			begin
				@(negedge clk);
				n++;
			end
			if (n >= 3000)
				tmo;
		end
	endtask
	// APB transfer: setup, access until ready, release
	task apb(input w, input [7:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge clk);
			psel <= 1'h1;
			penable <= 1'h0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'h1;
			k = 0;
			// Ready, read data and error are all taken at the completing edge
			@(posedge clk);
			while (pready !== 1'h1 && k < 100)
			begin
				@(posedge clk);
				k++;
			end
			if (k >= 100)
				tmo;
			r = prdata;
			se = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task svc;
		begin
			pr;
			apb(1'h1, `SMRSE_OFS_CTRL, 32'h0000_0001);
			drain;
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		{rst_n, psel, penable, pwrite, rx_valid, stall, fail, rnd} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rx_data = 8'h00;
		errors = 0;
		total_checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(negedge clk);
		chk("mode", `SMRSE_M_NORM, mode);
		svc;
		apb(1'h0, 8'h0C, 32'h0000_0000);
		chk("slverr", 1, se);
		$display("test entry done");
		// every rate and the trigger code
		for (i = 0; i < 5; i++)
		begin
			if (i < 4)
				ea(`SMRSE_C_RATE, av[i]);
			else
				e(`SMRSE_C_EXT);
			pr;
			line({"m ", rs[i]});
			drain;
			chk("rate sel", i, rate_sel);
			chk("ext trig", i == 4, ext_trig);
		end
		$display("test rates done");
		for (i = 0; i < 8; i++)
		begin
			e(ec[i]);
			pr;
			line(el[i]);
			drain;
		end
		chk("rate kept", `SMRSE_REXT, rate_sel);
		$display("test errors done");
		e(`SMRSE_C_SASK);
		e(`SMRSE_C_ABORT);
		e(`SMRSE_C_E003);
		pr;
		line("s");
		line("y");
		e(`SMRSE_C_SASK);
		e(`SMRSE_C_ABORT);
		pr;
		line("s");
		line("N");
		drain;
		rnd = 1'h1;
		for (i = 1; i <= 1001; i++)
		begin
			e(`SMRSE_C_SASK);
			ea(`SMRSE_C_SAVED, i[15:0]);
			if (i > 1000)
				e(`SMRSE_C_E004);
			pr;
			line("s");
			line("Y");
		end
		drain;
		rnd = 1'h0;
		apb(1'h0, `SMRSE_OFS_SCNT, 32'h0000_0000);
		chk("save count", 32'h0000_03E9, {16'h0000, r[15:0]});
		fail <= 1'h1;
		e(`SMRSE_C_SASK);
		e(`SMRSE_C_E005);
		pr;
		line("s");
		line("Y");
		drain;
		fail = 1'h0;
		$display("test save done");
		ea(`SMRSE_C_RATE, 16'h00FA);
		pr;
		e(`SMRSE_C_XASK);
		pr;
		e(`SMRSE_C_XASK);
		e(`SMRSE_C_E003);
		pr;
		e(`SMRSE_C_XASK);
		e(`SMRSE_C_RINIT);
		line("m 250");
		line("x n");
		line("N");
		line("x n");
		line("Q");
		line("x i");
		send("Y");
		drain;
		wm(`SMRSE_M_INIT);
		chk("hold", 1, n >= H - 1 && n <= H + 3);
		wm(`SMRSE_M_NORM);
		chk("reload", `SMRSE_REXT, rate_sel);
		svc;
		ea(`SMRSE_C_RATE, 16'h01F4);
		pr;
		e(`SMRSE_C_RNORM);
		line("m 500");
		line("x N");
		wm(`SMRSE_M_NORM);
		chk("fast exit", 1, n <= 3);
		drain;
		chk("rate live", `SMRSE_R500, rate_sel);
		svc;
		e(`SMRSE_C_RINIT);
		line("x I");
		// Init lasts one cycle, so it is watched before the reply drains
		wm(`SMRSE_M_INIT);
		chk("fast init", 1, n <= 3);
		drain;
		wm(`SMRSE_M_NORM);
		chk("discard", `SMRSE_REXT, rate_sel);
		svc;
		e(`SMRSE_C_RNORM);
		line("x n");
		drain;
		wm(`SMRSE_M_NORM);
		chk("clean hold", 1, n >= H - 1 && n <= H + 3);
		$display("test exit done");
		stop_test;
	end
endmodule

bind smrse_top smrse_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_smrse_checker (
	.I_CLK(I_CLK), .I_RST_N(I_RST_N), .O_RX_READY(O_RX_READY), .O_RSP_VALID(O_RSP_VALID),
	.O_RSP_CODE(O_RSP_CODE), .O_RSP_ARG(O_RSP_ARG), .I_RSP_READY(I_RSP_READY),
	.O_NVM_REQ(O_NVM_REQ), .O_NVM_DATA(O_NVM_DATA), .I_NVM_DONE(I_NVM_DONE),
	.I_NVM_FAIL(I_NVM_FAIL), .O_RATE_SEL(O_RATE_SEL), .O_EXT_TRIG(O_EXT_TRIG), .O_MODE(O_MODE));
`default_nettype wire
